/* File: verilog/coc_regs.svh */
// offsets, field positions, reset values and fixed codes of the option logic
// assumes inclusion by the package and the top module only
`ifndef COC_REGS_SVH
`define COC_REGS_SVH
`define COC_MISC_CMD 8'hF0
`define COC_MISC_RESET 16'h00C3
`define COC_MISC_RW_MASK 16'h000F
`define COC_OPT_RESET 8'h47
`define COC_OPT_AUTO_ARA_BIT 6
`define COC_OPT_SSDIS_BIT 7
`define COC_MISC_OVREL_BIT 0
`define COC_MISC_TRIM_LSB 1
`define COC_MISC_FSYNC_BIT 3
`define COC_TEMP_25C 12'h019
`define COC_NFLT 8
`endif

/* File: verilog/coc_pkg.sv */
// types shared by the option logic files
// assumes coc_regs.svh beside it
`include "coc_regs.svh"
package coc_pkg;
  typedef enum logic [1:0] {
    COC_TRIM_NONE = 2'b00,
    COC_TRIM_P125 = 2'b01,
    COC_TRIM_M250 = 2'b10,
    COC_TRIM_M125 = 2'b11
  } coc_trim_t;
  typedef struct packed {
    logic force_sync;
    coc_trim_t trim;
    logic ov_release_select;
  } coc_misc_t;
  typedef enum logic [1:0] {
    COC_LS_IDLE = 2'b00,
    COC_LS_HELD = 2'b01
  } coc_ls_state_t;
endpackage

/* File: verilog/coc_ls_latch.sv */
// low-side switch latch after an output overvoltage fault
// assumes fault and event inputs are single-cycle pulses on ref_clk
`timescale 1ns/100ps
`default_nettype none
module coc_ls_latch
  import coc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ov_fault,
  input wire logic ov_ignore,
  input wire logic release_select,
  input wire logic below_uv_limit,
  input wire logic startup_begin,
  input wire logic clear_faults,
  input wire logic disabled_state,
  output logic ls_on
);
  coc_ls_state_t state, next_state;
  always_comb begin
    next_state = state;
    case (state)
      COC_LS_IDLE: begin
        if (ov_fault && !ov_ignore) next_state = COC_LS_HELD;
      end
      COC_LS_HELD: begin
        if (release_select) begin
          if (below_uv_limit) next_state = COC_LS_IDLE;
        end else if (startup_begin || (clear_faults && disabled_state)) begin
          next_state = COC_LS_IDLE;
        end
        // a fresh fault holds the switch on regardless of a release
        if (ov_fault && !ov_ignore) next_state = COC_LS_HELD;
      end
      default: next_state = COC_LS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) state <= COC_LS_IDLE;
    else state <= next_state;
  end
  assign ls_on = (state == COC_LS_HELD);
endmodule // coc_ls_latch
`default_nettype wire

/* File: verilog/coc_option_logic.sv */
// option and configuration registers of the step-down controller
// assumes a command decoder on ref_clk giving code, write strobe and data
`timescale 1ns/100ps
`default_nettype none
`include "coc_regs.svh"
module coc_option_logic
  import coc_pkg::*;
#(
  parameter int NFLT = `COC_NFLT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_wdata,
  input wire logic [7:0] opt_wdata,
  input wire logic opt_write,
  input wire logic store_default_all,
  input wire logic ara_answered,
  input wire logic [NFLT-1:0] fault_src,
  input wire logic ov_fault,
  input wire logic ov_ignore,
  input wire logic below_uv_limit,
  input wire logic startup_begin,
  input wire logic clear_faults,
  input wire logic disabled_state,
  input wire logic voltage_set_valid_pin,
  input wire logic sync_reset_pin,
  input wire logic [11:0] temp_meas,
  output logic [15:0] misc_rdata,
  output logic [7:0] opt_rdata,
  output logic [NFLT-1:0] fault_mask,
  output logic alert_n,
  output logic softstart_detect_en,
  output logic [11:0] ext_temp,
  output logic nvm_write,
  output logic [15:0] nvm_misc_data,
  output logic [1:0] highside_overcurrent_trim,
  output logic signed [7:0] highside_overcurrent_delta,
  output logic sync_in,
  output logic pin_reset_n,
  output logic ls_switch_on
);
  coc_misc_t misc, next_misc;
  logic [7:0] opts, next_opts;
  logic [NFLT-1:0] next_fault_mask;
  logic [15:0] next_nvm_misc_data;
  logic next_nvm_write;
  logic [1:0] sync_pin_sr;
  logic [1:0] volt_set_sr;
  logic ls_on;
  logic auto_alert_mask_enable, softstart_detect_disable;

  // options byte: bit 6 auto alert mask, bit 7 soft-start detect disable
  assign auto_alert_mask_enable = opts[`COC_OPT_AUTO_ARA_BIT];
  assign softstart_detect_disable = opts[`COC_OPT_SSDIS_BIT];

  always_comb begin
    next_misc = misc;
    next_opts = opts;
    next_nvm_write = 1'b0;
    next_nvm_misc_data = nvm_misc_data;
    // bits 15:4 of a write are dropped
    if (cmd_write && cmd_code == `COC_MISC_CMD) begin
      next_misc = coc_misc_t'(cmd_wdata[3:0]);
    end
    if (opt_write) next_opts = opt_wdata;
    // store-all snapshots the live word; the memory side owns write timing
    if (store_default_all) begin
      next_nvm_write = 1'b1;
      next_nvm_misc_data = (`COC_MISC_RESET & ~`COC_MISC_RW_MASK) | {12'h000, misc};
    end
  end

  // each fault bit masks independently; host unmask write loses to auto mask
  // host unmask is coarse: any other command clears every mask bit below bit 16
  genvar gi;
  generate
    for (gi = 0; gi < NFLT; gi++) begin : g_mask
      always_comb begin
        next_fault_mask[gi] = fault_mask[gi];
        if (cmd_write && cmd_code != `COC_MISC_CMD && gi < 16)
          next_fault_mask[gi] = 1'b0;
        if (auto_alert_mask_enable && ara_answered && fault_src[gi])
          next_fault_mask[gi] = 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // only the four writable bits are stored; the rest are constants
      misc <= coc_misc_t'(4'(`COC_MISC_RESET & `COC_MISC_RW_MASK));
      opts <= `COC_OPT_RESET;
      fault_mask <= '0;
      nvm_write <= 1'b0;
      nvm_misc_data <= `COC_MISC_RESET;
    end else begin
      misc <= next_misc;
      opts <= next_opts;
      fault_mask <= next_fault_mask;
      nvm_write <= next_nvm_write;
      nvm_misc_data <= next_nvm_misc_data;
    end
  end

  // pins are asynchronous to ref_clk
  logic [1:0] next_sync_pin_sr;
  logic [1:0] next_volt_set_sr;
  always_comb begin
    next_sync_pin_sr = {sync_pin_sr[0], sync_reset_pin};
    next_volt_set_sr = {volt_set_sr[0], voltage_set_valid_pin};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_pin_sr <= 2'b11;
      volt_set_sr <= 2'b00;
    end else begin
      sync_pin_sr <= next_sync_pin_sr;
      volt_set_sr <= next_volt_set_sr;
    end
  end

  // low-side latch kept apart so its release paths can be exercised alone
  coc_ls_latch u_ls (
    .ref_clk(ref_clk),
    .rst(rst),
    .ov_fault(ov_fault),
    .ov_ignore(ov_ignore),
    .release_select(misc.ov_release_select),
    .below_uv_limit(below_uv_limit),
    .startup_begin(startup_begin),
    .clear_faults(clear_faults),
    .disabled_state(disabled_state),
    .ls_on(ls_on)
  );

  // threshold step in eighths of the default, 12.5% per count
  logic signed [7:0] next_delta;
  always_comb begin
    case (misc.trim)
      COC_TRIM_NONE: next_delta = 8'sh00;
      COC_TRIM_P125: next_delta = 8'sh01;
      COC_TRIM_M250: next_delta = -8'sh02;
      COC_TRIM_M125: next_delta = -8'sh01;
      default: next_delta = 8'sh00;
    endcase
  end

  // role follows the synchronised detection level, never the raw pin
  logic reset_role;
  assign reset_role = !misc.force_sync && volt_set_sr[1];

  logic [15:0] next_misc_rdata;
  logic [7:0] next_opt_rdata;
  logic next_alert_n;
  logic next_softstart_detect_en;
  logic [11:0] next_ext_temp;
  logic [1:0] next_trim;
  logic next_sync_in;
  logic next_pin_reset_n;
  logic next_ls_switch_on;
  always_comb begin
    // upper bits are read-only and always show their defaults
    next_misc_rdata = (`COC_MISC_RESET & ~`COC_MISC_RW_MASK) | {12'h000, misc};
    next_opt_rdata = opts;
    // unmasked persistent fault keeps alert low when auto mask is off
    next_alert_n = ~|(fault_src & ~fault_mask);
    next_softstart_detect_en = ~softstart_detect_disable;
    // pin sets the rise time while detection is on, so no reading exists
    next_ext_temp = softstart_detect_disable ? temp_meas : `COC_TEMP_25C;
    next_trim = misc.trim;
    // reset role: sync input idles high; sync role: reset stays released
    next_sync_in = reset_role ? 1'b1 : sync_pin_sr[1];
    next_pin_reset_n = reset_role ? sync_pin_sr[1] : 1'b1;
    next_ls_switch_on = ls_on;
  end

  // every output leaves from a flop; reset values match the register defaults
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      misc_rdata <= `COC_MISC_RESET;
      opt_rdata <= `COC_OPT_RESET;
      alert_n <= 1'b1;
      softstart_detect_en <= 1'b1;
      ext_temp <= `COC_TEMP_25C;
      highside_overcurrent_trim <= 2'b01;
      highside_overcurrent_delta <= 8'sh01;
      sync_in <= 1'b1;
      pin_reset_n <= 1'b1;
      ls_switch_on <= 1'b0;
    end else begin
      misc_rdata <= next_misc_rdata;
      opt_rdata <= next_opt_rdata;
      alert_n <= next_alert_n;
      softstart_detect_en <= next_softstart_detect_en;
      ext_temp <= next_ext_temp;
      highside_overcurrent_trim <= next_trim;
      highside_overcurrent_delta <= next_delta;
      sync_in <= next_sync_in;
      pin_reset_n <= next_pin_reset_n;
      ls_switch_on <= next_ls_switch_on;
    end
  end
endmodule // coc_option_logic
`default_nettype wire

/* File: testbench/coc_option_logic_chk.sv */
// port assertions for the option logic
// assumes it is bound to coc_option_logic
`timescale 1ns/100ps
`default_nettype none
module coc_option_logic_chk #(parameter int NFLT = 8) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_wdata,
  input wire logic store_default_all,
  input wire logic ara_answered,
  input wire logic [NFLT-1:0] fault_src,
  input wire logic [7:0] opt_rdata,
  input wire logic [NFLT-1:0] fault_mask,
  input wire logic [15:0] misc_rdata,
  input wire logic nvm_write,
  input wire logic ov_fault,
  input wire logic ov_ignore,
  input wire logic ls_switch_on,
  input wire logic [1:0] highside_overcurrent_trim,
  input wire logic signed [7:0] highside_overcurrent_delta
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_misc_wr;
    cmd_write && cmd_code == 8'hF0;
  endsequence
  sequence s_ov_ign;
    ov_fault && ov_ignore && !ls_switch_on && !$past(ov_fault) ##1 !ov_fault;
  endsequence
  a_misc_write_upd: assert property (
    s_misc_wr |-> ##2 misc_rdata[3:0] == $past(cmd_wdata[3:0], 2))
    else $error("misc register missed a write");
  a_misc_upper_fixed: assert property (misc_rdata[15:4] == 12'h00C)
    else $error("misc upper bits changed");
  a_nvm_on_store: assert property (nvm_write == $past(store_default_all))
    else $error("store pulse and nvm write differ");
  a_auto_mask_set: assert property (
    ara_answered && opt_rdata[6] |=> (fault_mask & $past(fault_src)) == $past(fault_src))
    else $error("set faults not masked after alert response");
  a_mask_kept_off: assert property (
    ara_answered && !opt_rdata[6] && !cmd_write |=> $stable(fault_mask))
    else $error("mask changed without auto masking");
  a_ov_latch_on: assert property (ov_fault && !ov_ignore |-> ##2 ls_switch_on)
    else $error("low-side switch not latched on");
  a_ov_ignored: assert property (s_ov_ign |-> ##1 !ls_switch_on)
    else $error("ignored fault latched the switch");
  a_trim_delta: assert property (
    $stable(highside_overcurrent_trim) |-> highside_overcurrent_delta ==
      (highside_overcurrent_trim == 2'b01 ? 8'sh01 :
       highside_overcurrent_trim == 2'b10 ? -8'sh02 :
       -$signed({7'h00, highside_overcurrent_trim[0]})))
    else $error("threshold step does not match trim");
endmodule // coc_option_logic_chk
bind coc_option_logic coc_option_logic_chk #(.NFLT(NFLT)) i_chk (.*);
`default_nettype wire

/* File: testbench/coc_host_model.sv */
// host side of the command port
// assumes the bench calls send after reset is released
`timescale 1ns/100ps
`default_nettype none
module coc_host_model (
  input wire logic ref_clk,
  output var logic [7:0] cmd_code,
  output var logic cmd_write,
  output var logic [15:0] cmd_wdata
);
  initial begin
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // any other code unmasks every source below 16 at once from the host side
  task automatic send(input logic [7:0] c, input logic [15:0] w);
    @(posedge ref_clk) cmd_write <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= w;
    @(posedge ref_clk) cmd_write <= 1'b0;
    cmd_wdata <= ~w;
  endtask
endmodule // coc_host_model
`default_nettype wire

/* File: testbench/tb_coc_option_logic.sv */
// bench for the option logic: misc words, alert masking, low-side latch
// assumes the host model drives the command port
`timescale 1ns/100ps
`default_nettype none
module tb_coc_option_logic;
  logic ref_clk = 0, rst = 1, opt_write = 0, store_default_all = 0, ara_answered = 0, cmd_write;
  logic ov_fault = 0, ov_ignore = 0, below_uv_limit = 0, startup_begin = 0, clear_faults = 0;
  logic disabled_state = 0, voltage_set_valid_pin = 0, sync_reset_pin = 1, alert_n;
  logic softstart_detect_en;
  logic [1:0] r;
  logic nvm_write, sync_in, pin_reset_n, ls_switch_on;
  logic [7:0] cmd_code, opt_wdata = 8'h47, opt_rdata, fault_src = 0, fault_mask;
  logic [15:0] cmd_wdata, misc_rdata, nvm_misc_data, d;
  logic [11:0] temp_meas = 12'h3A5, ext_temp;
  logic [1:0] highside_overcurrent_trim;
  logic signed [7:0] highside_overcurrent_delta;
  int err_total = 0, total_checks = 0, seed = 89;
  always #2 ref_clk = ~ref_clk;
  coc_option_logic i_dut (.*);
  coc_host_model i_host (.*);
  // step in eighths: +12.5% is +1, -25% is -2, -12.5% is -1
  function automatic logic signed [7:0] delta(input logic [1:0] t);
    return t == 2'b01 ? 8'sh01 : t == 2'b10 ? -8'sh02 : (t[0] ? -8'sh01 : 8'sh00);
  endfunction
  // {sync_in, pin_reset_n} for force-sync, detection valid and pin level
  function automatic logic [1:0] pin_roles(input logic fs, input logic vs, input logic pin);
    return (!fs && vs) ? {1'b1, pin} : {pin, 1'b1};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // outputs are looked at on the falling edge, where they have settled
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic ov_pulse;
    @(posedge ref_clk) ov_fault <= 1;
    @(posedge ref_clk) ov_fault <= 0;
    settle(2);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    chk(misc_rdata, 16'h00C3);
    chk(ext_temp, 12'h019);
    chk(opt_rdata, 8'h47);
    chk(softstart_detect_en, 1);
    chk(highside_overcurrent_trim, 2'b01);
    chk(ls_switch_on, 0);
    for (int i = 0; i < 16; i++) begin
      d = 16'($random(seed));
      d[3:1] = i[2:0];
      d[8] = i[3];
      @(posedge ref_clk) voltage_set_valid_pin <= d[8];
      sync_reset_pin <= d[9];
      i_host.send(8'hF0, d);
      settle(5);
      r = pin_roles(d[3], d[8], d[9]);
      chk(misc_rdata, {12'h00C, d[3:0]});
      chk(highside_overcurrent_trim, d[2:1]);
      chk(highside_overcurrent_delta, delta(d[2:1]));
      chk(sync_in, r[1]);
      chk(pin_reset_n, r[0]);
    end
    $display("misc word test done");
    @(posedge ref_clk) store_default_all <= 1;
    @(posedge ref_clk) store_default_all <= 0;
    @(negedge ref_clk);
    chk(nvm_write, 1);
    chk(nvm_misc_data, {12'h00C, d[3:0]});
    settle(1);
    chk(nvm_write, 0);
    @(posedge ref_clk) fault_src <= 8'($random(seed)) | 8'h01;
    settle(2);
    chk(alert_n, 0);
    @(posedge ref_clk) ara_answered <= 1;
    @(posedge ref_clk) ara_answered <= 0;
    settle(2);
    chk(fault_mask, fault_src);
    chk(alert_n, 1);
    @(posedge ref_clk) opt_wdata <= 8'h87;
    opt_write <= 1;
    @(posedge ref_clk) opt_write <= 0;
    i_host.send(8'h03, 16'h0000);
    @(posedge ref_clk) ara_answered <= 1;
    @(posedge ref_clk) ara_answered <= 0;
    settle(3);
    chk(fault_mask, 0);
    chk(alert_n, 0);
    chk(opt_rdata, 8'h87);
    chk(softstart_detect_en, 0);
    chk(ext_temp, 12'h3A5);
    $display("alert and option test done");
    i_host.send(8'hF0, 16'h0000);
    ov_pulse();
    chk(ls_switch_on, 1);
    @(posedge ref_clk) below_uv_limit <= 1;
    disabled_state <= 1;
    settle(3);
    chk(ls_switch_on, 1);
    @(posedge ref_clk) clear_faults <= 1;
    @(posedge ref_clk) clear_faults <= 0;
    settle(2);
    chk(ls_switch_on, 0);
    ov_pulse();
    chk(ls_switch_on, 1);
    @(posedge ref_clk) startup_begin <= 1;
    @(posedge ref_clk) startup_begin <= 0;
    settle(2);
    chk(ls_switch_on, 0);
    @(posedge ref_clk) below_uv_limit <= 0;
    i_host.send(8'hF0, 16'h0001);
    ov_pulse();
    chk(ls_switch_on, 1);
    @(posedge ref_clk) below_uv_limit <= 1;
    settle(3);
    chk(ls_switch_on, 0);
    @(posedge ref_clk) ov_ignore <= 1;
    below_uv_limit <= 0;
    ov_pulse();
    chk(ls_switch_on, 0);
    $display("low-side latch test done");
    finish_test();
  end
endmodule // tb_coc_option_logic
`default_nettype wire
